// File: hw/ostm_regs.svh
// Timing constants for the orthogonal subcarrier timing link
`ifndef OSTM_REGS_SVH
`define OSTM_REGS_SVH

`define OSTM_CLK_HZ       200000000
`define OSTM_TICK_HZ      2560
`define OSTM_DIV_CYC      (`OSTM_CLK_HZ / `OSTM_TICK_HZ)
`define OSTM_RX_DLY_US    700
`define OSTM_RX_DLY_CYC   ((`OSTM_CLK_HZ / 1000000) * `OSTM_RX_DLY_US)

`define OSTM_BURST_LAST   8'h9f
`define OSTM_MCAR_END     8'h40
`define OSTM_MOD_START    8'h10
`define OSTM_MOD_END      8'h30
`define OSTM_RCAR_START   8'h40
`define OSTM_RPL_START    8'h50
`define OSTM_RPL_END      8'h70
`define OSTM_RCAR_END     8'h80
`define OSTM_WIN_SAMPLES  6'h20

`define OSTM_N_CHAN       16
`define OSTM_CHAN_BASE    6'h09
`define OSTM_REF_IDX      6'h20

`endif

// File: hw/ostm_pkg.sv
// Types and waveform function for the orthogonal subcarrier timing link
`include "ostm_regs.svh"
package ostm_pkg;

  typedef enum logic [1:0] {
    RPL_IDLE,
    RPL_ARMED,
    RPL_SEND
  } ostm_reply_state_t;

  typedef logic [5:0] ostm_idx_t;

  // Polarity of subcarrier idx at phase ph (64 steps per interval); 1 = negative
  function automatic logic ostm_subcarrier(input ostm_idx_t idx, input logic [5:0] ph);
    logic [5:0] g;
    logic       r;
    g = ph ^ {1'b0, ph[5:1]};
    r = 1'b0;
    for (int k = 0; k < 6; k++) begin
      r = r ^ (idx[k] & g[5-k]);
    end
    return r;
  endfunction

  function automatic ostm_idx_t ostm_chan_idx(input logic [3:0] chan);
    return 6'(`OSTM_CHAN_BASE + {2'h0, chan});
  endfunction

endpackage

// File: hw/ostm_link_if.sv
// Link between master and remote ends of the subcarrier timing system
`timescale 1ns/1ps
`default_nettype none
interface ostm_link_if;
  logic        m_carrier;
  logic        m_mod;
  logic        m_ref_wave;
  logic [15:0] m_chan_wave;
  logic        r_carrier;
  logic        r_mod;
  logic        r_ref_wave;
  logic        r_data_wave;

  modport master (
    output m_carrier, m_mod, m_ref_wave, m_chan_wave,
    input  r_carrier, r_mod, r_ref_wave, r_data_wave
  );
  modport remote (
    input  m_carrier, m_mod, m_ref_wave, m_chan_wave,
    output r_carrier, r_mod, r_ref_wave, r_data_wave
  );
endinterface
`default_nettype wire

// File: hw/ostm_master.sv
// Master end: timing chain, subcarrier generator, query rotation, delayed receive timing
`timescale 1ns/1ps
`default_nettype none
`include "ostm_regs.svh"

// ==========================================================================
// Timing chain: clock divider to the 2560 cps tick, tick position in burst
// ==========================================================================
module ostm_timebase #(
  parameter int DIV_CYC = `OSTM_DIV_CYC
) (
  input  wire logic       clk_i,      // System clock
  input  wire logic       resetn_i,   // Async reset, active low
  input  wire logic       run_i,      // Chain advances while high
  input  wire logic       realign_i,  // Force tick position to zero
  output logic            tick_o,     // Last clock of a tick
  output logic            sample_o,   // Quarter point of a tick
  output logic            half_o,     // Second half of a tick
  output logic [7:0]      pos_o,      // Tick index within burst
  output logic [3:0]      burst_o,    // Burst index within second
  output logic [5:0]      phase_o     // Phase in T/64 steps
);
  localparam int DW = $clog2(DIV_CYC);

  logic [DW-1:0] div_reg;
  logic [DW-1:0] div_next;
  logic [7:0]    pos_reg;
  logic [7:0]    pos_next;
  logic [3:0]    burst_reg;
  logic [3:0]    burst_next;
  wire           wrap;
  wire           pos_last;

  assign wrap       = div_reg == DW'(DIV_CYC - 1);
  assign pos_last   = pos_reg == `OSTM_BURST_LAST;
  assign div_next   = wrap ? '0 : DW'(div_reg + 1'b1);
  assign pos_next   = !wrap ? pos_reg : (pos_last ? 8'h00 : 8'(pos_reg + 8'h01));
  assign burst_next = (wrap && pos_last) ? 4'(burst_reg + 4'h1) : burst_reg;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_reg   <= '0;
      pos_reg   <= 8'h00;
      burst_reg <= 4'h0;
    end else if (realign_i) begin
      div_reg   <= '0;
      pos_reg   <= 8'h00;
    end else if (run_i) begin
      div_reg   <= div_next;
      pos_reg   <= pos_next;
      burst_reg <= burst_next;
    end
  end

  assign tick_o   = run_i & wrap;
  assign sample_o = run_i & (div_reg == DW'(DIV_CYC / 4));
  assign half_o   = div_reg >= DW'(DIV_CYC / 2);
  assign pos_o    = pos_reg;
  assign burst_o  = burst_reg;
  // Interval of 32 ticks starts at modulation start (tick 16)
  assign phase_o  = {~pos_reg[4], pos_reg[3:0], half_o};
endmodule // ostm_timebase

// ==========================================================================
// Master station
// ==========================================================================
module ostm_master #(
  parameter int DIV_CYC    = `OSTM_DIV_CYC,
  parameter int RX_DLY_CYC = `OSTM_RX_DLY_CYC
) (
  input  wire logic        clk_i,          // System clock, 200 MHz
  input  wire logic        resetn_i,       // Async reset, active low
  ostm_link_if.master      link,           // Radio link side
  output logic             carrier_o,      // Transmit carrier enable
  output logic             mod_o,          // Transmit modulation window
  output logic [3:0]       slot_o,         // Slot queried this burst
  output logic [15:0]      query_o,        // One-hot queried channel
  output logic             ref_wave_o,     // Reference subcarrier
  output logic [15:0]      chan_wave_o,    // Data subcarriers, query inverted
  output logic             rx_ready_o,     // Delayed timing running
  output logic             rx_window_o,    // Delayed reply window
  output logic [3:0]       rx_slot_o,      // Slot of expected reply
  output logic             rx_ref_wave_o,  // Delayed local reference
  output logic [15:0]      rx_chan_wave_o, // Delayed local data subcarriers
  output logic             rx_reply_o      // Reply modulation seen in window
);
  // ========================================================================
  // Transmit timing
  // ========================================================================
  logic       tx_half;
  logic [7:0] tx_pos;
  logic [3:0] tx_burst;
  logic [5:0] tx_phase;

  ostm_timebase #(.DIV_CYC(DIV_CYC)) u_tx_tb (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .run_i     (1'b1),
    .realign_i (1'b0),
    .tick_o    (),
    .sample_o  (),
    .half_o    (tx_half),
    .pos_o     (tx_pos),
    .burst_o   (tx_burst),
    .phase_o   (tx_phase)
  );

  wire        tx_carrier;
  wire        tx_mod;
  wire        tx_ref;
  wire [15:0] tx_query;
  wire [15:0] tx_wave;

  assign tx_carrier = tx_pos < `OSTM_MCAR_END;
  assign tx_mod     = (tx_pos >= `OSTM_MOD_START) && (tx_pos < `OSTM_MOD_END);
  assign tx_ref     = ostm_pkg::ostm_subcarrier(`OSTM_REF_IDX, tx_phase);
  assign tx_query   = 16'h0001 << tx_burst;

  // ========================================================================
  // Data subcarriers, one per channel
  // ========================================================================
  genvar c;
  generate
    for (c = 0; c < `OSTM_N_CHAN; c++) begin : g_tx_chan
      // Query replaces the command level with the inverted waveform
      assign tx_wave[c] = ostm_pkg::ostm_subcarrier(ostm_pkg::ostm_chan_idx(4'(c)), tx_phase)
                          ^ tx_query[c];
    end
  endgenerate

  // ========================================================================
  // Receive timing, held back by the equipment delay
  // ========================================================================
  localparam int RW = $clog2(RX_DLY_CYC + 1);

  logic [RW-1:0] rx_dly_reg;
  logic          rx_go_reg;
  wire           rx_dly_done;

  assign rx_dly_done = rx_dly_reg == RW'(RX_DLY_CYC - 1);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_dly_reg <= '0;
      rx_go_reg  <= 1'b0;
    end else if (!rx_go_reg) begin
      rx_dly_reg <= RW'(rx_dly_reg + 1'b1);
      rx_go_reg  <= rx_dly_done;
    end
  end

  logic [7:0] rx_pos;
  logic [3:0] rx_burst;
  logic [5:0] rx_phase;

  // Same divider as transmit, started a fixed delay later: phase stays locked
  ostm_timebase #(.DIV_CYC(DIV_CYC)) u_rx_tb (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .run_i     (rx_go_reg),
    .realign_i (1'b0),
    .tick_o    (),
    .sample_o  (),
    .half_o    (),
    .pos_o     (rx_pos),
    .burst_o   (rx_burst),
    .phase_o   (rx_phase)
  );

  wire        rx_win;
  wire        rx_ref;
  wire [15:0] rx_wave;

  assign rx_win = rx_go_reg && (rx_pos >= `OSTM_RPL_START) && (rx_pos < `OSTM_RPL_END);
  assign rx_ref = ostm_pkg::ostm_subcarrier(`OSTM_REF_IDX, rx_phase);

  generate
    for (c = 0; c < `OSTM_N_CHAN; c++) begin : g_rx_chan
      assign rx_wave[c] = ostm_pkg::ostm_subcarrier(ostm_pkg::ostm_chan_idx(4'(c)), rx_phase);
    end
  endgenerate

  // ========================================================================
  // Output registers
  // ========================================================================
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      carrier_o      <= 1'b0;
      mod_o          <= 1'b0;
      slot_o         <= 4'h0;
      query_o        <= 16'h0000;
      ref_wave_o     <= 1'b0;
      chan_wave_o    <= 16'h0000;
      rx_window_o    <= 1'b0;
      rx_slot_o      <= 4'h0;
      rx_ref_wave_o  <= 1'b0;
      rx_chan_wave_o <= 16'h0000;
      rx_reply_o     <= 1'b0;
    end else begin
      carrier_o      <= tx_carrier;
      mod_o          <= tx_mod;
      slot_o         <= tx_burst;
      query_o        <= tx_query;
      ref_wave_o     <= tx_ref;
      chan_wave_o    <= tx_wave;
      rx_window_o    <= rx_win;
      rx_slot_o      <= rx_burst;
      rx_ref_wave_o  <= rx_ref;
      rx_chan_wave_o <= rx_wave;
      rx_reply_o     <= rx_win & link.r_mod;
    end
  end

  assign rx_ready_o = rx_go_reg;

  // Link side mirrors the registered transmit outputs
  assign link.m_carrier   = carrier_o;
  assign link.m_mod       = mod_o;
  assign link.m_ref_wave  = ref_wave_o;
  assign link.m_chan_wave = chan_wave_o;

  // Half-tick flag unused here; tx_phase already carries it for the reference
  wire unused_ok;
  assign unused_ok = tx_half;
endmodule // ostm_master
`default_nettype wire

// File: hw/ostm_remote.sv
// Remote end: slaved timing, query detection by correlation, gated reply
`timescale 1ns/1ps
`default_nettype none
`include "ostm_regs.svh"

// ==========================================================================
// Remote station
// ==========================================================================
module ostm_remote #(
  parameter int DIV_CYC = `OSTM_DIV_CYC
) (
  input  wire logic        clk_i,        // System clock, 200 MHz
  input  wire logic        resetn_i,     // Async reset, active low
  ostm_link_if.remote      link,         // Radio link side
  input  wire logic [3:0]  chan_sel_i,   // Assigned channel 0..15
  input  wire logic        reply_neg_i,  // Reply data polarity
  output logic             in_sync_o,    // Reference fully matched last burst
  output logic             queried_o,    // Valid query seen, one-cycle pulse
  output logic             replying_o,   // Reply carrier active
  output logic             local_ref_o   // Local reference flip-flop
);
  // ========================================================================
  // Timing slaved to master carrier turn-on
  // ========================================================================
  logic m_car_reg;
  wire  realign;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      m_car_reg <= 1'b0;
    end else begin
      m_car_reg <= link.m_carrier;
    end
  end

  assign realign = link.m_carrier & ~m_car_reg;

  logic       tick;
  logic       sample;
  logic [7:0] pos;
  logic [5:0] phase;

  ostm_timebase #(.DIV_CYC(DIV_CYC)) u_tb (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .run_i     (1'b1),
    .realign_i (realign),
    .tick_o    (tick),
    .sample_o  (sample),
    .half_o    (),
    .pos_o     (pos),
    .burst_o   (),
    .phase_o   (phase)
  );

  // Local reference toggled once per oscillator tick
  logic lref_reg;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lref_reg <= 1'b0;
    end else if (realign) begin
      lref_reg <= 1'b0;
    end else if (tick) begin
      lref_reg <= ~lref_reg;
    end
  end

  // ========================================================================
  // Correlation over the master modulation window
  // ========================================================================
  wire       in_win;
  wire       my_wave;
  wire       my_ref;
  wire       eval;
  logic [5:0] inv_cnt_reg;
  logic [5:0] ref_cnt_reg;

  assign in_win  = (pos >= `OSTM_MOD_START) && (pos < `OSTM_MOD_END);
  assign my_wave = ostm_pkg::ostm_subcarrier(ostm_pkg::ostm_chan_idx(chan_sel_i), phase);
  assign my_ref  = ostm_pkg::ostm_subcarrier(`OSTM_REF_IDX, phase);
  assign eval    = tick && (pos == (`OSTM_MOD_END - 8'h01));

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      inv_cnt_reg <= 6'h00;
      ref_cnt_reg <= 6'h00;
    end else if (realign) begin
      inv_cnt_reg <= 6'h00;
      ref_cnt_reg <= 6'h00;
    end else if (sample && in_win) begin
      inv_cnt_reg <= 6'(inv_cnt_reg + {5'h00, link.m_chan_wave[chan_sel_i] ^ my_wave});
      ref_cnt_reg <= 6'(ref_cnt_reg + {5'h00, ~(link.m_ref_wave ^ my_ref)});
    end
  end

  wire sync_ok;
  wire query_ok;
  assign sync_ok  = ref_cnt_reg == `OSTM_WIN_SAMPLES;
  assign query_ok = sync_ok && (inv_cnt_reg == `OSTM_WIN_SAMPLES);

  // ========================================================================
  // Reply sequencing
  // ========================================================================
  ostm_pkg::ostm_reply_state_t st_reg;
  ostm_pkg::ostm_reply_state_t st_next;

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      ostm_pkg::RPL_IDLE:  if (eval && query_ok) st_next = ostm_pkg::RPL_ARMED;
      ostm_pkg::RPL_ARMED: if (pos == `OSTM_RCAR_START) st_next = ostm_pkg::RPL_SEND;
      ostm_pkg::RPL_SEND:  if (pos == `OSTM_RCAR_END) st_next = ostm_pkg::RPL_IDLE;
      default:             st_next = ostm_pkg::RPL_IDLE;
    endcase
  end

  wire send;
  wire r_mod;
  assign send  = st_reg == ostm_pkg::RPL_SEND;
  assign r_mod = send && (pos >= `OSTM_RPL_START) && (pos < `OSTM_RPL_END);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_reg      <= ostm_pkg::RPL_IDLE;
      in_sync_o   <= 1'b0;
      queried_o   <= 1'b0;
      replying_o  <= 1'b0;
      local_ref_o <= 1'b0;
      link.r_carrier   <= 1'b0;
      link.r_mod       <= 1'b0;
      link.r_ref_wave  <= 1'b0;
      link.r_data_wave <= 1'b0;
    end else begin
      st_reg      <= st_next;
      if (eval) begin
        in_sync_o <= sync_ok;
      end
      queried_o   <= eval && query_ok;
      replying_o  <= send;
      local_ref_o <= lref_reg;
      link.r_carrier   <= send;
      link.r_mod       <= r_mod;
      link.r_ref_wave  <= r_mod & my_ref;
      link.r_data_wave <= r_mod & (my_wave ^ reply_neg_i);
    end
  end
endmodule // ostm_remote
`default_nettype wire

// File: tb/ostm_link_properties.sv
// Timing properties watched on the link between master and remote
`timescale 1ns/1ps
`default_nettype none
module ostm_link_properties #(
  parameter int DIV_CYC = 32
) (
  input wire logic        clk_i,       // System clock
  input wire logic        resetn_i,    // Async reset, active low
  input wire logic        m_carrier,   // Master carrier
  input wire logic        m_mod,       // Master modulation window
  input wire logic        m_ref_wave,  // Master reference wave
  input wire logic [15:0] m_chan_wave, // Master data waves
  input wire logic        r_carrier,   // Remote carrier
  input wire logic        r_mod,       // Remote modulation window
  input wire logic        r_ref_wave,  // Remote reference echo
  input wire logic        r_data_wave  // Remote data reply
);
  localparam int BURST = 160 * DIV_CYC;
  logic        car_q_reg;
  logic        ref_q_reg;
  logic        seen_reg;
  logic [31:0] per_reg;
  logic [31:0] mod_reg;
  logic [31:0] car_reg;
  logic [31:0] rmod_reg;
  logic [31:0] ref_reg;
  wire         car_rise = m_carrier & ~car_q_reg;

  // ==========================================================================
  // Cycle counters
  // ==========================================================================
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {car_q_reg, ref_q_reg, seen_reg} <= 3'h0;
      {per_reg, mod_reg, car_reg, rmod_reg, ref_reg} <= '0;
    end else begin
      car_q_reg <= m_carrier;
      ref_q_reg <= m_ref_wave;
      seen_reg  <= seen_reg | car_rise;
      per_reg   <= car_rise ? 32'h0 : per_reg + 32'h1;
      mod_reg   <= m_mod ? mod_reg + 32'h1 : 32'h0;
      car_reg   <= m_carrier ? car_reg + 32'h1 : 32'h0;
      rmod_reg  <= r_mod ? rmod_reg + 32'h1 : 32'h0;
      ref_reg   <= (m_ref_wave != ref_q_reg) ? 32'h0 : ref_reg + 32'h1;
    end
  end

  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  property p_burst_period;
    car_rise && seen_reg |-> per_reg == BURST - 1;
  endproperty
  property p_mod_len;
    $fell(m_mod) |-> mod_reg == 32 * DIV_CYC;
  endproperty
  property p_mod_start;
    $rose(m_mod) |-> per_reg == 16 * DIV_CYC - 1;
  endproperty
  property p_mod_in_car;
    m_mod |-> m_carrier;
  endproperty
  property p_car_len;
    $fell(m_carrier) |-> car_reg == 64 * DIV_CYC;
  endproperty
  property p_start_pos;
    $rose(m_mod) |-> !m_ref_wave && $onehot0(m_chan_wave);
  endproperty
  property p_ref_toggle;
    m_mod |-> ref_reg < DIV_CYC && (m_ref_wave == ref_q_reg || ref_reg == DIV_CYC - 1);
  endproperty
  property p_rcar_after;
    $rose(r_carrier) |-> !m_carrier && per_reg >= 64 * DIV_CYC - 1 && per_reg <= 64 * DIV_CYC + 3;
  endproperty
  property p_rmod_start;
    $rose(r_mod) |-> r_carrier && per_reg >= 80 * DIV_CYC - 1 && per_reg <= 80 * DIV_CYC + 3;
  endproperty
  property p_rmod_len;
    $fell(r_mod) |-> rmod_reg == 32 * DIV_CYC && r_carrier;
  endproperty
  property p_reply_quiet;
    !r_mod |-> !r_ref_wave && !r_data_wave && !(r_carrier && m_carrier);
  endproperty

  a_burst_period: assert property (p_burst_period) else $error("burst period wrong");
  a_mod_len: assert property (p_mod_len) else $error("modulation length wrong");
  a_mod_start: assert property (p_mod_start) else $error("modulation start wrong");
  a_mod_in_car: assert property (p_mod_in_car) else $error("modulation outside carrier");
  a_car_len: assert property (p_car_len) else $error("carrier length wrong");
  a_start_pos: assert property (p_start_pos) else $error("interval start level wrong");
  a_ref_toggle: assert property (p_ref_toggle) else $error("reference toggle spacing");
  a_rcar_after: assert property (p_rcar_after) else $error("remote carrier timing");
  a_rmod_start: assert property (p_rmod_start) else $error("reply start wrong");
  a_rmod_len: assert property (p_rmod_len) else $error("reply length wrong");
  a_reply_quiet: assert property (p_reply_quiet) else $error("remote output outside reply");

  c_reply: cover property ($rose(r_mod));
  c_query: cover property ($rose(m_mod) && m_chan_wave != 16'h0);
  c_burst: cover property (car_rise && seen_reg);
endmodule // ostm_link_properties
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench joining master and remote ends of the timing link
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int DIV = 32;
  localparam int RXD = 56; // Receive delay, about 1.75 ticks
  logic        clk_i    = 1'b0;
  logic        resetn_i = 1'b0;
  logic [3:0]  sel_a    = 4'h0;
  logic [3:0]  sel_b    = 4'h0;
  logic        neg_a    = 1'b0;
  logic        neg_b    = 1'b0;
  logic        carrier_o, rx_ready_o, rx_reply_o, sync_a, queried_a, replying_a;
  logic        sync_b, queried_b, replying_b;
  logic [3:0]  slot_o, rx_slot_o;
  logic [15:0] query_o;
  logic        got_q = 1'b0, got_rep = 1'b0, got_rx = 1'b0, got_bad = 1'b0;
  logic [3:0]  rx_seen = 4'h0;
  logic [4:0]  notes[$];
  int          num_errors = 0;
  int          n_tests = 0;
  logic        rx_window_o, rx_ref_wave_o, lref_a, lref_q, rmod_q, rdat_q;
  logic [15:0] rx_chan_wave_o;
  logic [16:0] hist[$];
  logic [16:0] past;
  int          n_hist = 0, n_win = 0, n_lref = 0, n_rev = 0;

  ostm_link_if link ();
  ostm_link_if link_bad ();
  assign link_bad.m_carrier   = link.m_carrier;
  assign link_bad.m_mod       = link.m_mod;
  assign link_bad.m_ref_wave  = ~link.m_ref_wave; // Reference broken on purpose
  assign link_bad.m_chan_wave = link.m_chan_wave;

  ostm_master #(.DIV_CYC(DIV), .RX_DLY_CYC(RXD)) ostm_master_i (
    .clk_i(clk_i), .resetn_i(resetn_i), .link(link), .carrier_o(carrier_o),
    .mod_o(), .slot_o(slot_o), .query_o(query_o), .ref_wave_o(), .chan_wave_o(),
    .rx_ready_o(rx_ready_o), .rx_window_o(rx_window_o), .rx_slot_o(rx_slot_o),
    .rx_ref_wave_o(rx_ref_wave_o), .rx_chan_wave_o(rx_chan_wave_o),
    .rx_reply_o(rx_reply_o));
  ostm_remote #(.DIV_CYC(DIV)) ostm_remote_i (
    .clk_i(clk_i), .resetn_i(resetn_i), .link(link), .chan_sel_i(sel_a),
    .reply_neg_i(neg_a), .in_sync_o(sync_a), .queried_o(queried_a),
    .replying_o(replying_a), .local_ref_o(lref_a));
  ostm_remote #(.DIV_CYC(DIV)) ostm_remote_x_i (
    .clk_i(clk_i), .resetn_i(resetn_i), .link(link_bad), .chan_sel_i(sel_b),
    .reply_neg_i(neg_b), .in_sync_o(sync_b), .queried_o(queried_b),
    .replying_o(replying_b), .local_ref_o());
  ostm_link_properties #(.DIV_CYC(DIV)) ostm_link_properties_i (
    .clk_i(clk_i), .resetn_i(resetn_i), .m_carrier(link.m_carrier), .m_mod(link.m_mod),
    .m_ref_wave(link.m_ref_wave), .m_chan_wave(link.m_chan_wave),
    .r_carrier(link.r_carrier), .r_mod(link.r_mod), .r_ref_wave(link.r_ref_wave),
    .r_data_wave(link.r_data_wave));

  always #2.5 clk_i = ~clk_i;

  // ==========================================================================
  // Compare and closing tasks
  // ==========================================================================
  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask
  task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d, errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================================
  // Result collection and monitor
  // ==========================================================================
  always @(posedge clk_i) begin
    if (queried_a === 1'b1) got_q = 1'b1;
    if (replying_a === 1'b1) got_rep = 1'b1;
    if (rx_reply_o === 1'b1) begin
      got_rx  = 1'b1;
      rx_seen = rx_slot_o;
    end
    if (queried_b === 1'b1 || replying_b === 1'b1) got_bad = 1'b1;
    if (rx_window_o === 1'b1) n_win++;
    if (lref_a !== lref_q) n_lref++;
    lref_q = lref_a;
    if (link.r_mod === 1'b1 && rmod_q === 1'b1 && link.r_data_wave !== rdat_q) n_rev++;
    if (link.r_mod === 1'b1 && rmod_q !== 1'b1) begin
      n_rev = 0;
      chk_bit(link.r_data_wave, neg_a, "reply start level");
    end
    if (link.r_mod !== 1'b1 && rmod_q === 1'b1) begin
      chk_vec(16'(n_rev), 16'(9 + sel_a), "reply reversals");
    end
    rmod_q = link.r_mod;
    rdat_q = link.r_data_wave;
    // Delayed receive waves against transmit waves RXD cycles earlier
    if (resetn_i === 1'b1) begin
      hist.push_back({link.m_ref_wave, link.m_chan_wave ^ query_o});
      n_hist++;
      if (hist.size() > RXD) begin
        past = hist.pop_front();
        if (n_hist > RXD + 1) begin
          chk_bit(rx_ref_wave_o, past[16], "delayed reference");
          chk_vec(rx_chan_wave_o, past[15:0], "delayed data waves");
        end
      end
    end
  end

  initial begin : monitor
    logic [4:0]  note;
    logic [3:0]  cur_slot;
    logic [15:0] cur_q;
    forever begin
      @(posedge carrier_o);
      if (notes.size() > 0) begin
        note = notes.pop_front();
        chk_vec({12'h0, cur_slot}, {12'h0, note[3:0]}, "burst slot");
        chk_vec(cur_q, 16'h1 << note[3:0], "queried channel");
        chk_bit(got_q, note[4], "query detected");
        chk_bit(got_rep, note[4], "reply carrier");
        chk_bit(got_rx, note[4], "reply received");
        if (note[4]) chk_vec({12'h0, rx_seen}, {12'h0, note[3:0]}, "reply slot");
        chk_bit(got_bad, 1'b0, "reply without reference");
        chk_bit(sync_a, 1'b1, "remote in sync");
        chk_bit(sync_b, 1'b0, "broken remote in sync");
        chk_bit(rx_ready_o, 1'b1, "delayed timing running");
        chk_vec(16'(n_win), 16'(32 * DIV), "receive window length");
        chk_vec(16'(n_lref), 16'h00a0, "local reference toggles");
      end
      {got_q, got_rep, got_rx, got_bad} = 4'h0;
      n_win  = 0;
      n_lref = 0;
      #1;
      cur_slot = slot_o;
      cur_q    = query_o;
    end
  end

  // ==========================================================================
  // Stimulus: one burst per pass, remote channel hits or misses the query
  // ==========================================================================
  initial begin : driver
    logic hit;
    void'($urandom(26989));
    repeat (3) @(posedge clk_i);
    #1 resetn_i = 1'b1;
    for (int k = 0; k < 16; k++) begin
      @(posedge carrier_o);
      #1;
      hit   = (k == 1) || ($urandom % 4 != 0);
      sel_a = hit ? k[3:0] : k[3:0] ^ 4'(1 + $urandom % 15);
      neg_a = 1'($urandom);
      sel_b = k[3:0];
      neg_b = 1'($urandom);
      if (k > 0) notes.push_back({hit, k[3:0]});
    end
    @(posedge carrier_o);
    #20;
    tally_and_finish();
  end

  initial begin : watchdog
    // Eighteen bursts of 160 ticks at 5 ns per clock
    #(18 * 160 * DIV * 5);
    num_errors++;
    $display("unexpected at %0t: timeout", $time);
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
